// ===== pdpwm_filter_model.sv
// low-pass filter stand-in: integrates pin high time per period
module pdpwm_filter_model (
    input  wire logic        i_clk,   // system clock
    input  wire logic        i_pin,   // pwm waveform
    input  wire logic        i_mark,  // period start strobe
    output logic      [31:0] o_total  // high clocks of last period
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] acc_q;
    // pin lags by one clock: the strobe cycle still shows the old
    // period's last level
    always_ff @(posedge i_clk) begin
        if (i_mark) begin
            o_total <= acc_q + {31'h0, i_pin};
            acc_q   <= 32'h0;
        end else begin
            acc_q <= acc_q + {31'h0, i_pin};
        end
    end
endmodule // pdpwm_filter_model

// ===== pdpwm_pkg.sv
// constants of the pulse-division pwm generator
package pdpwm_pkg;

    // register byte addresses
    localparam logic [15:0] PDPWM_ADDR_CLOCK_SELECT = 16'hffd0;
    localparam logic [15:0] PDPWM_ADDR_DUTY_UPPER   = 16'hffd1;
    localparam logic [15:0] PDPWM_ADDR_DUTY_LOWER   = 16'hffd2;

    // values after reset
    localparam logic [7:0]  PDPWM_RST_CLOCK_SELECT  = 8'hfe;
    localparam logic [7:0]  PDPWM_RST_DUTY_UPPER    = 8'hc0;
    localparam logic [7:0]  PDPWM_RST_DUTY_LOWER    = 8'h00;
    localparam logic [13:0] PDPWM_RST_DUTY          = 14'h0000;

    // read answers
    localparam logic [7:0]  PDPWM_READ_ONES         = 8'hff;
    localparam logic [7:0]  PDPWM_READ_UNMAPPED     = 8'h00;

    // field positions
    localparam int          PDPWM_PERIOD_SELECT_BIT = 0;
    localparam int          PDPWM_UPPER_DUTY_MSB    = 5;
    localparam int          PDPWM_COARSE_LSB        = 6;

    // waveform structure
    localparam int          PDPWM_SYS_CLK_HZ        = 50000000;
    localparam int          PDPWM_PULSES            = 64;
    localparam int          PDPWM_STEPS_PER_PULSE   = 256;
    localparam logic [8:0]  PDPWM_HIGH_OFFSET_STEPS = 9'h001;
    localparam logic [8:0]  PDPWM_FULL_PULSE_STEPS  = 9'h100;
    localparam int          PDPWM_PERIOD_DIV2_CYC   = 16384;
    localparam int          PDPWM_PERIOD_DIV4_CYC   = 32768;

endpackage : pdpwm_pkg

// ===== pdpwm_properties.sv
// port assertions of the pulse-division pwm generator
module pdpwm_properties
    import pdpwm_pkg::*;
(
    input  wire logic        i_clk,                      // system clock
    input  wire logic        i_nrst,                     // sync reset, low
    input  wire logic [15:0] i_addr,                     // address
    input  wire logic  [7:0] i_wdata,                    // write data
    input  wire logic        i_wr,                       // write strobe
    input  wire logic        i_rd,                       // read strobe
    input  wire logic        i_port_function_select_one, // pin route
    input  wire logic  [7:0] o_rdata,                    // read data
    input  wire logic        o_shared_output_pin,        // waveform
    input  wire logic        o_period_start              // period strobe
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    logic [15:0] gap_q;
    logic        seen_q;
    // first period after reset has no earlier start to measure from
    always_ff @(posedge i_clk) begin
        gap_q  <= (!i_nrst || o_period_start) ? 16'h0001 : gap_q + 16'h0001;
        seen_q <= i_nrst && (seen_q || o_period_start);
    end
    sequence s_rd_at(logic [15:0] a);
        i_rd && i_addr == a;
    endsequence
    sequence s_unrouted;
        !i_port_function_select_one [*2];
    endsequence
    a_read_ctrl: assert property (
        s_rd_at(PDPWM_ADDR_CLOCK_SELECT) |=> o_rdata == 8'hff)
        else $error("control read not all ones");
    a_read_upper: assert property (
        s_rd_at(PDPWM_ADDR_DUTY_UPPER) |=> o_rdata == 8'hff)
        else $error("upper duty read not all ones");
    a_read_lower: assert property (
        s_rd_at(PDPWM_ADDR_DUTY_LOWER) |=> o_rdata == 8'hff)
        else $error("lower duty read not all ones");
    a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data outside read answer");
    a_unmapped_read: assert property (
        i_rd && !(i_addr inside {[16'hffd0:16'hffd2]}) |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_pin_gated: assert property (
        s_unrouted |-> !o_shared_output_pin)
        else $error("pin driven while not routed");
    a_start_single: assert property (o_period_start |=> !o_period_start)
        else $error("period strobe longer than one clock");
    a_period_length: assert property (
        o_period_start && seen_q |-> gap_q inside {16'h4000, 16'h8000})
        else $error("period length wrong");
    a_start_high: assert property (
        o_period_start && i_port_function_select_one
        |=> o_shared_output_pin)
        else $error("pulse not high at period start");
endmodule // pdpwm_properties

bind pdpwm_top pdpwm_properties chk_u (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_port_function_select_one(i_port_function_select_one),
    .o_rdata(o_rdata), .o_shared_output_pin(o_shared_output_pin),
    .o_period_start(o_period_start));

// ===== pdpwm_timebase.sv
// step, pulse and period counters of the pwm generator
module pdpwm_timebase
    import pdpwm_pkg::*;
(
    input  wire logic       i_clk,          // system clock
    input  wire logic       i_nrst,         // sync reset, active low
    input  wire logic       i_div4,         // 1: step every two clocks
    output logic            o_step,         // step strobe
    output logic      [7:0] o_pos,          // step inside the pulse
    output logic      [5:0] o_idx,          // pulse inside the period
    output logic            o_period_end    // last step of a period
);

    logic       pre_q;
    logic       step_now;
    logic       last_now;
    logic [7:0] pos_q;
    logic [5:0] idx_q;

    // divide-by-4 input clock yields a two-clock step
    assign step_now = i_div4 ? pre_q : 1'b1;
    assign last_now = step_now && (pos_q == 8'hff) && (idx_q == 6'h3f);

    // phase restarts at each boundary, else the first step of a slow
    // period after a fast one could last a single clock
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            pre_q <= 1'b0;
        end else begin
            pre_q <= last_now ? 1'b0 : ~pre_q;
        end
    end

    always_ff @(posedge i_clk) begin
        // counters rest on the last step, so the first clock after
        // reset is a period boundary like any other
        if (!i_nrst) begin
            pos_q <= 8'hff;
            idx_q <= 6'h3f;
        end else if (step_now) begin
            pos_q <= pos_q + 8'h01;
            if (pos_q == 8'hff) begin
                idx_q <= idx_q + 6'h01;
            end
        end
    end

    assign o_step       = step_now;
    assign o_pos        = pos_q;
    assign o_idx        = idx_q;
    assign o_period_end = last_now;

endmodule // pdpwm_timebase

// ===== pdpwm_top.sv
// pulse-division pwm generator with byte register port
//
// The plain strobed port was left to the implementer.
module pdpwm_top
    import pdpwm_pkg::*;
(
    input  wire logic        i_clk,                  // system clock
    input  wire logic        i_nrst,                 // sync reset, low
    input  wire logic [15:0] i_addr,                 // register address
    input  wire logic  [7:0] i_wdata,                // write data
    input  wire logic        i_wr,                   // write strobe
    input  wire logic        i_rd,                   // read strobe
    input  wire logic        i_port_function_select_one, // pin route
    output logic       [7:0] o_rdata,                // read data
    output logic             o_shared_output_pin,    // pwm waveform
    output logic             o_period_start          // first step strobe
);

    // software-side registers
    logic        period_select_q;
    logic  [7:0] duty_upper_byte_q;
    logic  [7:0] duty_lower_byte_q;
    logic [13:0] duty_pending_q;

    // generator-side state, changed only at the boundary
    logic [13:0] duty_active_q;
    logic        div4_active_q;

    // outputs
    logic  [7:0] rdata_q;
    logic  [7:0] rdata_d;
    logic        pin_q;
    logic        pin_d;
    logic        period_start_q;

    // timebase
    logic        step;
    logic  [7:0] pos;
    logic  [5:0] idx;
    logic        period_end;

    // pulse shaping
    logic  [8:0] pulse_high;
    logic        extra_step;

    logic        wr_ctrl;
    logic        wr_upper;
    logic        wr_lower;

    // bit-reversed pulse index scatters the spare steps over the period
    function automatic logic [5:0] bit_rev6(input logic [5:0] v);
        logic [5:0] r;
        r = 6'h00;
        for (int k = 0; k < 6; k++) begin
            r[k] = v[5 - k];
        end
        return r;
    endfunction

    function automatic logic is_addr(input logic [15:0] a,
                                     input logic [15:0] reg_addr);
        return a == reg_addr;
    endfunction

    assign wr_ctrl  = i_wr && is_addr(i_addr, PDPWM_ADDR_CLOCK_SELECT);
    assign wr_upper = i_wr && is_addr(i_addr, PDPWM_ADDR_DUTY_UPPER);
    assign wr_lower = i_wr && is_addr(i_addr, PDPWM_ADDR_DUTY_LOWER);

    pdpwm_timebase u_timebase (
        .i_clk        (i_clk),
        .i_nrst       (i_nrst),
        .i_div4       (div4_active_q),
        .o_step       (step),
        .o_pos        (pos),
        .o_idx        (idx),
        .o_period_end (period_end)
    );

    // control register: only bit 0 is stored, the rest is constant
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            period_select_q <= PDPWM_RST_CLOCK_SELECT[PDPWM_PERIOD_SELECT_BIT];
        end else if (wr_ctrl) begin
            period_select_q <= i_wdata[PDPWM_PERIOD_SELECT_BIT];
        end
    end

    // lower byte is only a holding stage until the upper write
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            duty_lower_byte_q <= PDPWM_RST_DUTY_LOWER;
        end else if (wr_lower) begin
            duty_lower_byte_q <= i_wdata;
        end
    end

    // top two bits of the upper byte stay at one
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            duty_upper_byte_q <= PDPWM_RST_DUTY_UPPER;
        end else if (wr_upper) begin
            duty_upper_byte_q <= {2'b11,
                i_wdata[PDPWM_UPPER_DUTY_MSB:0]};
        end
    end

    // upper write captures both bytes at once; a lower write alone
    // never disturbs the waveform
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            duty_pending_q <= PDPWM_RST_DUTY;
        end else if (wr_upper) begin
            duty_pending_q <= {i_wdata[PDPWM_UPPER_DUTY_MSB:0],
                duty_lower_byte_q};
        end
    end

    // generator takes new duty and period only at the period edge,
    // so no period is ever built from two values
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            duty_active_q <= PDPWM_RST_DUTY;
            div4_active_q <= PDPWM_RST_CLOCK_SELECT[PDPWM_PERIOD_SELECT_BIT];
        end else if (period_end) begin
            duty_active_q <= duty_pending_q;
            div4_active_q <= period_select_q;
        end
    end

    // each pulse gets coarse+1 steps, plus one where extra_step is set; the 64 offset steps sum to 64
    always_comb begin
        extra_step = bit_rev6(idx) < duty_active_q[5:0];
        pulse_high = {1'b0, duty_active_q[13:PDPWM_COARSE_LSB]}
                   + PDPWM_HIGH_OFFSET_STEPS
                   + {8'h00, extra_step};
    end

    // a full pulse cannot exceed its length, so the top code saturates
    always_comb begin
        if (pulse_high >= PDPWM_FULL_PULSE_STEPS) begin
            pin_d = 1'b1;
        end else begin
            pin_d = {1'b0, pos} < pulse_high;
        end
        pin_d = pin_d && i_port_function_select_one;
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= pin_d;
        end
    end

    // strobe stands in the new period's first clock only, so two
    // strobes are exactly one period apart in either mode
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            period_start_q <= 1'b0;
        end else begin
            period_start_q <= period_end;
        end
    end

    // all mapped registers are write-only and answer all ones
    always_comb begin
        rdata_d = PDPWM_READ_UNMAPPED;
        if (is_addr(i_addr, PDPWM_ADDR_CLOCK_SELECT)) begin
            rdata_d = PDPWM_READ_ONES;
        end else if (is_addr(i_addr, PDPWM_ADDR_DUTY_UPPER) ||
                     is_addr(i_addr, PDPWM_ADDR_DUTY_LOWER)) begin
            rdata_d = PDPWM_READ_ONES;
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            rdata_q <= 8'h00;
        end else if (i_rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign o_rdata             = rdata_q;
    assign o_shared_output_pin = pin_q;
    assign o_period_start      = period_start_q;

endmodule // pdpwm_top

// ===== tb.sv
// self-checking bench of the pulse-division pwm generator
module tb
    import pdpwm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic        route = 1'b1;
    logic [15:0] i_addr = 16'h0000;
    logic  [7:0] i_wdata = 8'h00, o_rdata;
    logic        pin, mark, sel [4];
    logic [31:0] total, seed = 32'h345dcfe7;
    logic [13:0] duty [4];
    int          miscompares = 0, tests_run = 0;
    time         t_last, t_now;
    pdpwm_top dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .i_port_function_select_one(route), .o_rdata(o_rdata),
        .o_shared_output_pin(pin), .o_period_start(mark));
    pdpwm_filter_model lpf_u (.i_clk(i_clk), .i_pin(pin), .i_mark(mark),
        .o_total(total));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [31:0] exp_high(input logic [13:0] d,
                                             input logic s);
        return ({18'h0, d} + 32'h40) << s;
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic bus_rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 cmp({24'h0, o_rdata}, {24'h0, exp});
    endtask
    // bounded: a period never exceeds 32768 clocks
    task automatic wait_mark();
        int n;
        n = 0;
        do begin
            @(posedge i_clk);
            #1 n++;
        end while (mark !== 1'b1 && n < 40000);
        if (n >= 40000) miscompares++;
    endtask
    task automatic give_verdict();
        $display("counts: %0d compares, %0d mismatches", tests_run,
                 miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial forever #10 i_clk = ~i_clk;
    // a clean run ends after about 98,320 clocks
    initial begin
        #2000000;
        miscompares++;
        give_verdict();
    end
    initial begin
        duty[0] = 14'h0000;
        sel[0]  = 1'b0;
        duty[1] = 14'h3fbf;
        sel[1]  = 1'b1;
        seed    = xs(seed);
        duty[2] = seed[13:0] % 14'h3fc0;
        sel[2]  = seed[20];
        seed    = xs(seed);
        duty[3] = seed[13:0] % 14'h3fc0;
        sel[3]  = ~sel[2];
        repeat (10) @(posedge i_clk);
        i_nrst <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            wait_mark();
            t_now = $time;
            if (i > 0) begin
                cmp(32'((t_now - t_last) / 64'h14), 32'h4000 << sel[i-1]);
                @(posedge i_clk);
                #1 cmp(total, exp_high(duty[i-1], sel[i-1]));
            end
            t_last = t_now;
            if (i < 3) begin
                seed = xs(seed);
                bus_wr(PDPWM_ADDR_CLOCK_SELECT, {seed[7:1], sel[i+1]});
                bus_wr(PDPWM_ADDR_DUTY_LOWER, duty[i+1][7:0]);
                bus_wr(PDPWM_ADDR_DUTY_UPPER, {seed[9:8], duty[i+1][13:8]});
                bus_wr(PDPWM_ADDR_DUTY_LOWER, seed[23:16]);
                for (int a = 0; a < 4; a++)
                    bus_rd(PDPWM_ADDR_CLOCK_SELECT + 16'(a), a < 3 ? 8'hff : 8'h00);
            end
            $display("period step %0d done", i);
        end
        @(posedge i_clk);
        route <= 1'b0;
        repeat (3) @(posedge i_clk);
        #1 cmp({31'h0, pin}, 32'h0);
        $display("pin routing test done");
        give_verdict();
    end
endmodule // tb
